// [ssf_pkg.sv]
package ssf_pkg;
   localparam int DW = 32;
   localparam int SLOTS = 8;
   localparam int SLOT_AW = 3;
   localparam int IDX_W = 7;
   localparam int LUT_AW = 9;
   localparam int LUT_DEPTH = 512;
   localparam int PORT_W = 3;
   localparam int NPORT = 8;
   localparam int ACK_W = 5;
   localparam int BUF_W = 39;
   localparam int DID_HI = 31;
   localparam int DID_LO = 16;
   localparam int FT_HI = 15;
   localparam int FT_LO = 12;
   localparam int HOP_HI = 7;
   localparam int HOP_LO = 0;
   localparam int OP_HI = 31;
   localparam int OP_LO = 28;
   localparam int OFS_HI = 23;
   localparam int CRC_HI = 15;
   localparam logic [3:0] FTYPE_MAINT = 4'h8;
   localparam logic [3:0] OP_WRITE = 4'h1;
   localparam logic [7:0] HOP_ONE = 8'h01;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;
   localparam logic [IDX_W-1:0] IDX_TWO = 7'h02;
   typedef enum logic [2:0] {
      CS_PA = 3'h0, CS_RETRY = 3'h1, CS_PNA = 3'h2, CS_BAD3 = 3'h3,
      CS_LREQ = 3'h4, CS_LRSP = 3'h5, CS_MCE = 3'h6, CS_BAD7 = 3'h7
   } ssf_cs_t;
   typedef enum logic [2:0] {
      RD_IDLE = 3'b001, RD_FWD = 3'b010, RD_REG = 3'b100
   } ssf_rd_t;
endpackage

// [ssf_port.sv]
`timescale 1ns/1ps
`default_nettype none
module ssf_port (
   input wire logic clock,
   input wire logic nrst,
   input wire logic store_fwd,
   input wire logic lut_hier,
   input wire logic [7:0] local_dom,
   input wire logic glut_en,
   input wire logic lut_we,
   input wire logic [ssf_pkg::LUT_AW-1:0] lut_waddr,
   input wire logic [3:0] lut_wdata,
   output logic [15:0] glut_idx,
   input wire logic [3:0] glut_entry,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic rx_sop,
   input wire logic rx_eop,
   input wire logic [ssf_pkg::DW-1:0] rx_data,
   input wire logic rx_crc_ok,
   input wire logic cs_valid,
   input wire logic [2:0] cs_type,
   input wire logic [ssf_pkg::ACK_W-1:0] cs_ackid,
   input wire logic cs_crc_ok,
   output logic pa_send,
   output logic pna_send,
   output logic link_maint,
   output logic mce_fwd,
   input wire logic [ssf_pkg::NPORT-1:0] egr_busy,
   output logic fab_valid,
   input wire logic fab_ready,
   output logic [ssf_pkg::DW-1:0] fab_data,
   output logic fab_sop,
   output logic fab_eop,
   output logic fab_err,
   output logic [ssf_pkg::PORT_W-1:0] fab_port,
   output logic fab_mcast,
   output logic reg_req,
   output logic reg_we,
   output logic [23:0] reg_addr,
   output logic [ssf_pkg::DW-1:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [ssf_pkg::DW-1:0] reg_rdata,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [ssf_pkg::ACK_W-1:0] tx_ackid,
   output logic [ssf_pkg::DW-1:0] tx_rdata
);
   import ssf_pkg::*;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [DW-1:0] d,
                                           input int n);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < n; i++) begin
         r = (r[15] ^ d[DW-1-i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   logic [DW-1:0] mem [0:SLOTS*(2**IDX_W)-1];
   logic [3:0] lut_q [0:LUT_DEPTH-1];
   logic [SLOTS-1:0] busy_q, done_q, ok_q, maint_q, hop0_q, mc_q;
   logic [PORT_W-1:0] port_q [0:SLOTS-1];
   logic [IDX_W-1:0] len_q [0:SLOTS-1];
   logic [SLOT_AW-1:0] wr_slot_q, free_slot, cur_slot, sel_q, pick, free_idx;
   logic [IDX_W-1:0] wr_idx_q, cur_idx, rd_idx_q;
   logic wr_act_q, have_free, wr_en, rx_bad;
   logic [LUT_AW-1:0] lut_idx;
   logic [3:0] route;
   ssf_rd_t rd_q;
   logic [SLOTS-1:0] c_bad, c_reg, c_fwd;
   logic pk_bad, pk_reg, pk_fwd, avail, last, push, rd_free;
   logic [DW-1:0] rd_word, out_word;
   logic [15:0] crc_q;
   logic tx_pend_q, tx_valid_q, cs_ok;
   logic [BUF_W-1:0] b_q [0:1];
   logic b_wp_q, b_rp_q;
   logic [1:0] b_cnt_q;
   logic b_in_ready;

   // ----------------------------------------
   // Ingress slot allocation and write
   // ----------------------------------------
   always_comb begin
      free_slot = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (!busy_q[i]) begin
            free_slot = SLOT_AW'(i);
         end
      end
   end
   assign have_free = ~&busy_q;
   assign rx_ready = wr_act_q | have_free;
   assign wr_en = rx_valid && rx_ready;
   assign rx_bad = wr_en && rx_eop && !rx_crc_ok;
   assign cur_slot = rx_sop ? free_slot : wr_slot_q;
   assign cur_idx = rx_sop ? '0 : wr_idx_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_slot_q <= '0;
         wr_idx_q <= '0;
         wr_act_q <= 1'b0;
      end else if (wr_en) begin
         wr_slot_q <= cur_slot;
         wr_idx_q <= cur_idx + IDX_ONE;
         wr_act_q <= !rx_eop;
      end
   end

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[{cur_slot, cur_idx}] <= rx_data;
      end
   end

   // ----------------------------------------
   // Destination lookup
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (lut_we) begin
         lut_q[lut_waddr] <= lut_wdata;
      end
   end
   assign glut_idx = rx_data[DID_HI:DID_LO];
   always_comb begin
      if (!lut_hier) begin
         lut_idx = rx_data[DID_LO+LUT_AW-1:DID_LO];
      end else if (rx_data[DID_HI:DID_HI-7] == local_dom) begin
         lut_idx = {1'b1, rx_data[DID_LO+7:DID_LO]};
      end else begin
         lut_idx = {1'b0, rx_data[DID_HI:DID_HI-7]};
      end
      route = glut_en ? glut_entry : lut_q[lut_idx];
   end

   // ----------------------------------------
   // Per-slot state
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy_q <= '0;
         done_q <= '0;
         ok_q <= '0;
         maint_q <= '0;
         hop0_q <= '0;
         mc_q <= '0;
         for (int i = 0; i < SLOTS; i++) begin
            port_q[i] <= '0;
            len_q[i] <= '0;
         end
      end else begin
         if (rd_free) begin
            busy_q[free_idx] <= 1'b0;
         end
         if (wr_en && rx_sop) begin
            busy_q[cur_slot] <= 1'b1;
            done_q[cur_slot] <= 1'b0;
            port_q[cur_slot] <= route[PORT_W-1:0];
            mc_q[cur_slot] <= route[PORT_W];
            maint_q[cur_slot] <= rx_data[FT_HI:FT_LO] == FTYPE_MAINT;
            hop0_q[cur_slot] <= rx_data[HOP_HI:HOP_LO] == '0;
         end
         if (wr_en && rx_eop) begin
            done_q[cur_slot] <= 1'b1;
            ok_q[cur_slot] <= rx_crc_ok;
            len_q[cur_slot] <= cur_idx + IDX_ONE;
         end
      end
   end

   // ----------------------------------------
   // Slot selection
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < SLOTS; i++) begin
         c_bad[i] = busy_q[i] && done_q[i] && !ok_q[i];
         c_reg[i] = busy_q[i] && done_q[i] && ok_q[i] && maint_q[i] && hop0_q[i]
                    && !tx_pend_q;
         c_fwd[i] = busy_q[i] && !(maint_q[i] && hop0_q[i]) && !egr_busy[port_q[i]]
                    && (!store_fwd || (done_q[i] && ok_q[i]));
      end
      pk_bad = |c_bad;
      pk_reg = !pk_bad && |c_reg;
      pk_fwd = !pk_bad && !pk_reg && |c_fwd;
      pick = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (pk_bad ? c_bad[i] : (pk_reg ? c_reg[i] : c_fwd[i])) begin
            pick = SLOT_AW'(i);
         end
      end
   end

   // ----------------------------------------
   // Read engine
   // ----------------------------------------
   assign rd_word = mem[{sel_q, rd_idx_q}];
   assign avail = done_q[sel_q] ? (rd_idx_q < len_q[sel_q]) : (rd_idx_q < wr_idx_q);
   assign last = done_q[sel_q] && (rd_idx_q == len_q[sel_q] - IDX_ONE);
   assign push = (rd_q == RD_FWD) && avail && b_in_ready;
   assign free_idx = (rd_q == RD_IDLE) ? pick : sel_q;
   assign rd_free = ((rd_q == RD_IDLE) && pk_bad) || (push && last)
                    || ((rd_q == RD_REG) && reg_ack);

   always_comb begin
      out_word = rd_word;
      if (maint_q[sel_q]) begin
         if (rd_idx_q == '0) begin
            out_word[HOP_HI:HOP_LO] = rd_word[HOP_HI:HOP_LO] - HOP_ONE;
         end
         if (last) begin
            out_word[CRC_HI:0] = crc_step(crc_q, rd_word, 16);
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_q <= RD_IDLE;
         sel_q <= '0;
         rd_idx_q <= '0;
         crc_q <= CRC_INIT;
      end else begin
         unique case (rd_q)
            RD_IDLE: begin
               sel_q <= pick;
               rd_idx_q <= '0;
               crc_q <= CRC_INIT;
               if (pk_reg) begin
                  rd_q <= RD_REG;
               end else if (pk_fwd) begin
                  rd_q <= RD_FWD;
               end
            end
            RD_FWD: begin
               if (push) begin
                  rd_idx_q <= rd_idx_q + IDX_ONE;
                  crc_q <= crc_step(crc_q, out_word, DW);
                  if (last) begin
                     rd_q <= RD_IDLE;
                  end
               end
            end
            RD_REG: begin
               if (reg_ack) begin
                  rd_q <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register bus access
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_req <= 1'b0;
         reg_we <= 1'b0;
         reg_addr <= '0;
         reg_wdata <= '0;
      end else if ((rd_q == RD_IDLE) && pk_reg) begin
         reg_req <= 1'b1;
         reg_we <= mem[{pick, IDX_ONE}][OP_HI:OP_LO] == OP_WRITE;
         reg_addr <= mem[{pick, IDX_ONE}][OFS_HI:0];
         reg_wdata <= mem[{pick, IDX_TWO}];
      end else if (reg_ack) begin
         reg_req <= 1'b0;
      end
   end

   // ----------------------------------------
   // Response transmit and retention
   // ----------------------------------------
   assign cs_ok = cs_crc_ok && (cs_type != CS_BAD3) && (cs_type != CS_BAD7);
   assign tx_valid = tx_valid_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_pend_q <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_ackid <= '0;
         tx_rdata <= '0;
      end else begin
         if ((rd_q == RD_REG) && reg_ack) begin
            tx_pend_q <= 1'b1;
            tx_valid_q <= 1'b1;
            tx_rdata <= reg_rdata;
         end else if (tx_valid_q && tx_ready) begin
            tx_valid_q <= 1'b0;
         end else if (cs_valid && cs_ok && tx_pend_q && !tx_valid_q) begin
            if ((cs_type == CS_PA) && (cs_ackid == tx_ackid)) begin
               tx_pend_q <= 1'b0;
               tx_ackid <= tx_ackid + 1'b1;
            end else if ((cs_type == CS_RETRY) || (cs_type == CS_PNA)) begin
               tx_valid_q <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Control symbol replies
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pa_send <= 1'b0;
         pna_send <= 1'b0;
         link_maint <= 1'b0;
         mce_fwd <= 1'b0;
      end else begin
         pa_send <= wr_en && rx_eop && rx_crc_ok;
         pna_send <= rx_bad || (cs_valid && !cs_ok);
         link_maint <= cs_valid && cs_ok && (cs_type == CS_LREQ);
         mce_fwd <= cs_valid && cs_ok && (cs_type == CS_MCE);
      end
   end

   // ----------------------------------------
   // Two-entry fabric buffer
   // ----------------------------------------
   assign b_in_ready = b_cnt_q != 2'h2;
   assign fab_valid = b_cnt_q != 2'h0;
   assign {fab_sop, fab_eop, fab_err, fab_mcast, fab_port, fab_data} = b_q[b_rp_q];

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         b_q[0] <= '0;
         b_q[1] <= '0;
         b_wp_q <= 1'b0;
         b_rp_q <= 1'b0;
         b_cnt_q <= 2'h0;
      end else begin
         if (push) begin
            b_q[b_wp_q] <= {rd_idx_q == '0, last, last && !ok_q[sel_q], mc_q[sel_q],
                            port_q[sel_q], out_word};
            b_wp_q <= !b_wp_q;
         end
         if (fab_valid && fab_ready) begin
            b_rp_q <= !b_rp_q;
         end
         b_cnt_q <= b_cnt_q + {1'b0, push} - {1'b0, fab_valid && fab_ready};
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_crc_nak;
      @(posedge clock) disable iff (!nrst) rx_bad |=> pna_send;
   endproperty
   a_crc_nak: assert property (p_crc_nak) else $error("bad packet not refused");
   property p_cs_bad;
      @(posedge clock) disable iff (!nrst)
         (cs_valid && !cs_crc_ok) |=> (pna_send && !mce_fwd && !link_maint);
   endproperty
   a_cs_bad: assert property (p_cs_bad) else $error("bad symbol not refused");
   property p_pa_release;
      @(posedge clock) disable iff (!nrst)
         (cs_valid && cs_ok && cs_type == CS_PA && cs_ackid == tx_ackid && tx_pend_q
          && !tx_valid_q) |=> (!tx_pend_q && tx_ackid == $past(tx_ackid) + 1'b1);
   endproperty
   a_pa_release: assert property (p_pa_release) else $error("ack not applied");
   property p_retain;
      @(posedge clock) disable iff (!nrst)
         (tx_pend_q && !(cs_valid && cs_type == CS_PA)) |=> tx_pend_q;
   endproperty
   a_retain: assert property (p_retain) else $error("response dropped early");
   property p_one_req;
      @(posedge clock) disable iff (!nrst)
         (reg_req && !reg_ack) |=> (reg_req && $stable(reg_addr) && $stable(reg_wdata));
   endproperty
   a_one_req: assert property (p_one_req) else $error("register request moved");
   property p_rsp_queued;
      @(posedge clock) disable iff (!nrst)
         (rd_q == RD_REG && reg_ack) |=> (tx_valid && tx_rdata == $past(reg_rdata));
   endproperty
   a_rsp_queued: assert property (p_rsp_queued) else $error("no response");
   property p_mce;
      @(posedge clock) disable iff (!nrst)
         (cs_valid && cs_crc_ok && cs_type == CS_MCE) |=> mce_fwd
            ##1 (mce_fwd == $past(cs_valid && cs_crc_ok && cs_type == CS_MCE));
   endproperty
   a_mce: assert property (p_mce) else $error("event symbol not forwarded");
   property p_full;
      @(posedge clock) disable iff (!nrst) (&busy_q && !wr_act_q) |-> !rx_ready;
   endproperty
   a_full: assert property (p_full) else $error("ninth packet accepted");
   property p_saf;
      @(posedge clock) disable iff (!nrst)
         (push && store_fwd) |-> (done_q[sel_q] && ok_q[sel_q]);
   endproperty
   a_saf: assert property (p_saf) else $error("early egress");
   property p_hop;
      @(posedge clock) disable iff (!nrst) (push && rd_idx_q == '0 && maint_q[sel_q])
         |-> out_word[HOP_HI:HOP_LO] == rd_word[HOP_HI:HOP_LO] - HOP_ONE;
   endproperty
   a_hop: assert property (p_hop) else $error("hop count not decremented");
   property p_plain;
      @(posedge clock) disable iff (!nrst) (push && !maint_q[sel_q]) |-> out_word == rd_word;
   endproperty
   a_plain: assert property (p_plain) else $error("packet modified");
   cv_reg: cover property (@(posedge clock) disable iff (!nrst) reg_req && reg_ack);
   c_stall: cover property (@(posedge clock) disable iff (!nrst) b_cnt_q == 2'h2);
   c_retry: cover property (@(posedge clock) disable iff (!nrst)
      cs_valid && cs_type == CS_RETRY && tx_pend_q);
endmodule
`default_nettype wire

// [ssf_port_x.sv]
`default_nettype none
`default_nettype wire

// [ssf_reg_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssf_reg_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] lat,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [23:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic reg_ack,
   output logic [31:0] reg_rdata,
   output int n_err
);
   logic [31:0] mem [16];
   logic [3:0] cnt_q;
   logic done_q;
   // ----------------------------------------
   // Register target with a variable delay.
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_ack <= 1'b0;
         reg_rdata <= 32'h0;
         cnt_q <= 4'h0;
         done_q <= 1'b0;
         n_err <= 0;
      end else begin
         reg_ack <= 1'b0;
         reg_rdata <= ~reg_rdata;
         done_q <= reg_ack;
         if (done_q && reg_req) begin
            n_err <= n_err + 1;
         end
         if (reg_req && !reg_ack && !done_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == lat) begin
               cnt_q <= 4'h0;
               reg_ack <= 1'b1;
               reg_rdata <= reg_we ? reg_wdata : mem[reg_addr[5:2]];
               if (reg_we) begin
                  mem[reg_addr[5:2]] <= reg_wdata;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// [serial_switch_packet_forwarding_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_switch_packet_forwarding_tb;
   import ssf_pkg::*;
   logic clock = 1'b0, nrst = 1'b0, store_fwd = 1'b1, lut_hier = 1'b0;
   logic glut_en = 1'b0, lut_we = 1'b0, rx_valid = 1'b0, rx_sop = 1'b0;
   logic rx_eop = 1'b0, rx_crc_ok = 1'b0, cs_valid = 1'b0, cs_crc_ok = 1'b0;
   logic fab_ready = 1'b1, tx_ready = 1'b0;
   logic [7:0] local_dom = 8'h00, egr_busy = 8'h00;
   logic [LUT_AW-1:0] lut_waddr = 9'h000;
   logic [3:0] lut_wdata = 4'h0, glut_entry = 4'h0, reg_lat = 4'h0;
   logic [DW-1:0] rx_data = 32'h0;
   logic [2:0] cs_type = 3'h0;
   logic [ACK_W-1:0] cs_ackid = 5'h00, tx_ackid;
   logic [15:0] glut_idx;
   logic rx_ready, pa_send, pna_send, link_maint, mce_fwd, fab_valid, fab_sop;
   logic fab_eop, fab_err, fab_mcast, reg_req, reg_we, reg_ack, tx_valid;
   logic [DW-1:0] fab_data, reg_wdata, reg_rdata, tx_rdata;
   logic [PORT_W-1:0] fab_port;
   logic [23:0] reg_addr;
   int reg_err, n_fail = 0, check_count = 0, n_pa = 0, n_pna = 0, n_lm = 0, n_mce = 0;
   logic [31:0] fq[$];
   logic [3:0] rq[$];
   logic err_seen = 1'b0;
   ssf_port u_dut (
      .clock, .nrst, .store_fwd, .lut_hier, .local_dom, .glut_en, .lut_we, .lut_waddr,
      .lut_wdata, .glut_idx, .glut_entry, .rx_valid, .rx_ready, .rx_sop, .rx_eop,
      .rx_data, .rx_crc_ok, .cs_valid, .cs_type, .cs_ackid, .cs_crc_ok, .pa_send,
      .pna_send, .link_maint, .mce_fwd, .egr_busy, .fab_valid, .fab_ready, .fab_data,
      .fab_sop, .fab_eop, .fab_err, .fab_port, .fab_mcast, .reg_req, .reg_we,
      .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .tx_valid, .tx_ready, .tx_ackid,
      .tx_rdata
   );
   ssf_reg_model u_reg (
      .clock, .nrst, .lat(reg_lat), .reg_req, .reg_we, .reg_addr, .reg_wdata,
      .reg_ack, .reg_rdata, .n_err(reg_err)
   );
   initial begin
      forever #25 clock = ~clock;
   end
   // ----------------------------------------
   // Output watchers.
   // ----------------------------------------
   always @(posedge clock) begin
      if (pa_send === 1'b1) n_pa++;
      if (pna_send === 1'b1) n_pna++;
      if (link_maint === 1'b1) n_lm++;
      if (mce_fwd === 1'b1) n_mce++;
      if (fab_valid === 1'b1 && fab_ready) begin
         fq.push_back(fab_data);
         if (fab_sop) rq.push_back({fab_mcast, fab_port});
         if (fab_eop) err_seen <= fab_err;
      end
   end
   // ----------------------------------------
   // Shared tasks.
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [31:0] d,
                                           input int n);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < n; i++) begin
         fb = r[15] ^ d[31-i];
         r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction
   function automatic bit met(input int sel, input int v);
      case (sel)
         0: return tx_valid === 1'b1;
         1: return n_pna >= v;
         default: return fq.size() >= v;
      endcase
   endfunction
   task automatic wait_until(input int sel, input int v);
      int t;
      t = 0;
      while (!met(sel, v) && t < 400) begin
         step(1);
         t++;
      end
      if (t >= 400) begin
         n_fail++;
         $display("[FAIL] wait %0d expected done seen timeout", sel);
         tally_and_finish();
      end
   endtask
   task automatic send(input logic [31:0] w[$], input logic ok);
      int t;
      foreach (w[i]) begin
         rx_valid = 1'b1;
         rx_sop = (i == 0);
         rx_eop = (i == w.size() - 1);
         rx_data = w[i];
         rx_crc_ok = ok;
         t = 0;
         while (rx_ready !== 1'b1 && t < 200) begin
            step(1);
            t++;
         end
         if (t >= 200) begin
            n_fail++;
            $display("[FAIL] rx_ready expected 1 seen timeout");
            tally_and_finish();
         end
         step(1);
      end
      rx_valid = 1'b0;
      step(1);
   endtask
   task automatic sym(input logic [2:0] ty, input logic [4:0] a, input logic ok);
      cs_valid = 1'b1;
      cs_type = ty;
      cs_ackid = a;
      cs_crc_ok = ok;
      step(1);
      cs_valid = 1'b0;
      step(1);
   endtask
   task automatic take();
      tx_ready = 1'b1;
      step(1);
      tx_ready = 1'b0;
      step(2);
      chk("tx_valid", 0, 32'(tx_valid));
   endtask
   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task automatic t_forward();
      logic [31:0] pk[$];
      pk = '{32'h0005_2000, 32'hA5A5_0001, 32'h1234_5678, 32'h0000_BEEF};
      lut_we = 1'b1;
      lut_waddr = 9'h005;
      lut_wdata = 4'h3;
      step(1);
      lut_waddr = 9'h106;
      lut_wdata = 4'hA;
      step(1);
      lut_we = 1'b0;
      fab_ready = 1'b0;
      send(pk, 1'b1);
      step(6);
      chk("fab_valid", 1, 32'(fab_valid));
      fab_ready = 1'b1;
      wait_until(2, 4);
      foreach (pk[i]) chk("fab_data", pk[i], fq[i]);
      chk("route", 32'h3, 32'(rq[0]));
      chk("pa", 1, 32'(n_pa));
   endtask
   task automatic t_hol();
      egr_busy = 8'h08;
      send('{32'h0005_2000, 32'h1111_1111, 32'h0000_0001}, 1'b1);
      send('{32'h0106_2000, 32'h2222_2222, 32'h0000_0002}, 1'b1);
      wait_until(2, 7);
      chk("hol", 32'h0106_2000, fq[4]);
      chk("mcast", 32'hA, 32'(rq[1]));
      egr_busy = 8'h00;
      wait_until(2, 10);
      chk("hol_next", 32'h0005_2000, fq[7]);
   endtask
   task automatic t_bad();
      send('{32'h0005_2000, 32'h3333_3333, 32'h0000_0003}, 1'b0);
      wait_until(1, 1);
      step(10);
      chk("store_bad", 10, 32'(fq.size()));
      chk("pa_bad", 3, 32'(n_pa));
      store_fwd = 1'b0;
      send('{32'h0005_2000, 32'h4444_4444, 32'h0000_0004}, 1'b0);
      wait_until(2, 13);
      wait_until(1, 2);
      chk("cut_err", 1, 32'(err_seen));
      chk("cut_data", 32'h4444_4444, fq[11]);
      store_fwd = 1'b1;
   endtask
   task automatic t_maint();
      logic [4:0] a;
      send('{32'h0009_8000, 32'h1000_0010, 32'hCAFE_F00D, 32'h0000_1111}, 1'b1);
      wait_until(0, 0);
      chk("reg_write", 32'hCAFE_F00D, u_reg.mem[4]);
      chk("rsp", 32'hCAFE_F00D, tx_rdata);
      a = tx_ackid;
      take();
      sym(CS_RETRY, a, 1'b1);
      wait_until(0, 0);
      take();
      reg_lat = 4'h6;
      send('{32'h0009_8000, 32'h0000_0010, 32'h0000_0000, 32'h0000_2222}, 1'b1);
      step(4);
      chk("reg_req", 0, 32'(reg_req));
      sym(CS_PA, a, 1'b1);
      chk("ackid", 32'(a + 5'h01), 32'(tx_ackid));
      wait_until(0, 0);
      chk("read_back", 32'hCAFE_F00D, tx_rdata);
      take();
      sym(CS_PNA, tx_ackid, 1'b1);
      wait_until(0, 0);
      take();
      sym(CS_PA, tx_ackid, 1'b1);
      chk("ackid2", 32'(a + 5'h02), 32'(tx_ackid));
      chk("no_fwd", 13, 32'(fq.size()));
      chk("reg_order", 0, 32'(reg_err));
   endtask
   task automatic t_symbols();
      sym(CS_BAD3, 5'h00, 1'b1);
      sym(CS_BAD7, 5'h00, 1'b1);
      sym(CS_MCE, 5'h00, 1'b0);
      sym(CS_LREQ, 5'h00, 1'b0);
      chk("pna_sym", 6, 32'(n_pna));
      sym(CS_LREQ, 5'h00, 1'b1);
      sym(CS_MCE, 5'h00, 1'b1);
      chk("link_maint", 1, 32'(n_lm));
      chk("mce_fwd", 1, 32'(n_mce));
      chk("pna_good", 6, 32'(n_pna));
   endtask
   task automatic t_hop();
      logic [15:0] c;
      c = crc_ref(CRC_INIT, 32'h0005_8001, 32);
      c = crc_ref(c, 32'h0000_0010, 32);
      c = crc_ref(c, 32'h1234_5678, 32);
      c = crc_ref(c, 32'h0000_0000, 16);
      send('{32'h0005_8002, 32'h0000_0010, 32'h1234_5678, 32'h0000_ABCD}, 1'b1);
      wait_until(2, 17);
      chk("hop_dec", 32'h0005_8001, fq[13]);
      chk("hop_mid", 32'h1234_5678, fq[15]);
      chk("hop_crc", {16'h0000, c}, fq[16]);
      chk("hop_route", 32'h3, 32'(rq[4]));
      chk("hop_err", 0, 32'(err_seen));
   endtask
   task automatic t_tables();
      lut_we = 1'b1;
      lut_waddr = 9'h122;
      lut_wdata = 4'h5;
      step(1);
      lut_waddr = 9'h007;
      lut_wdata = 4'h6;
      step(1);
      lut_we = 1'b0;
      lut_hier = 1'b1;
      local_dom = 8'h01;
      send('{32'h0122_2000, 32'h0000_0005}, 1'b1);
      send('{32'h0700_2000, 32'h0000_0006}, 1'b1);
      glut_en = 1'b1;
      glut_entry = 4'h4;
      rx_data = 32'hABCD_0000;
      step(1);
      chk("glut_idx", 32'hABCD, 32'(glut_idx));
      send('{32'h0033_2000, 32'h0000_0007}, 1'b1);
      wait_until(2, 23);
      chk("hier_local", 32'h5, 32'(rq[5]));
      chk("hier_remote", 32'h6, 32'(rq[6]));
      chk("shared", 32'h4, 32'(rq[7]));
      glut_en = 1'b0;
      lut_hier = 1'b0;
   endtask
   task automatic t_full();
      egr_busy = 8'hFF;
      repeat (SLOTS) send('{32'h0005_2000, 32'h0000_0008}, 1'b1);
      chk("full_ready", 0, 32'(rx_ready));
      egr_busy = 8'h00;
      wait_until(2, 39);
      chk("full_drain", 32'h0000_0008, fq[38]);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1;
      nrst = 1'b1;
      t_forward();
      t_hol();
      t_bad();
      t_maint();
      t_hop();
      t_tables();
      t_full();
      t_symbols();
      tally_and_finish();
   end
endmodule
`default_nettype wire
